// ---- shared/flash_erase_cfg.svh ----
`ifndef FLASH_ERASE_CFG_SVH
`define FLASH_ERASE_CFG_SVH
// Command addresses and data words
`define UNLOCK_ADDR1 26'h0000555
`define UNLOCK_ADDR2 26'h00002aa
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_DATA2 16'h0055
`define SETUP_DATA 16'h0080
`define CHIP_CODE 16'h0010
`define SECTOR_CODE 16'h0030
`define SUSPEND_CODE 16'h00b0
`define RESUME_CODE 16'h0030
`define STATUS_READ_CODE 16'h0070
`define STATUS_CLEAR_CODE 16'h0071
`define SOFT_RESET_CODE 16'h00f0
`define ERASED_WORD 16'hffff
// Status word field
`define READY_BIT 7
// Bus timing in cycles of the 20 MHz clock
`define STROBE_CYCLES 4'h3
// Acceptance window in ns and its cycle count (longest time, round down)
`define ACCEPT_WINDOW_NS 50000
`define ACCEPT_WINDOW_CYC ((`ACCEPT_WINDOW_NS) / 50)
// Reset pulse and recovery in ns
`define RESET_PULSE_NS 500
`define RESET_PULSE_CYC (((`RESET_PULSE_NS) + 49) / 50)
`define RECOVERY_NS 50000
`define RECOVERY_CYC (((`RECOVERY_NS) + 49) / 50)
`endif

// ---- shared/flash_erase_pkg.sv ----
`default_nettype none
package flash_erase_pkg;
   // Orders taken from the user side
   typedef enum logic [2:0] {
      CMD_CHIP = 3'h0,
      CMD_SECTOR = 3'h1,
      CMD_ADD_SECTOR = 3'h2,
      CMD_SUSPEND = 3'h3,
      CMD_RESUME = 3'h4,
      CMD_STATUS = 3'h5,
      CMD_CLEAR = 3'h6,
      CMD_HW_RESET = 3'h7
   } cmd_e;
   // Pins toward the flash
   typedef struct packed {
      logic [25:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
      logic we_n;
      logic oe_n;
      logic ce_n;
      logic reset_n;
   } flash_pins_s;
endpackage : flash_erase_pkg
`default_nettype wire

// ---- hdl/flash_erase_ctrl.sv ----
// Operation
// - Chip erase is six writes; device busy after sixth write strobe.
// - After an abort the host reissues the whole erase sequence.
// - Sector erase is six writes, sixth carries sector address and code.
// - Host writes each extra sector before the window expires.
// - After failed program in suspend, clear, then resume before programming.
// - Unlock pair: AAh to 555h, then 55h to 2AAh.
`include "flash_erase_cfg.svh"
`default_nettype none
module flash_erase_ctrl #(
   parameter int ACCEPT_CYC = `ACCEPT_WINDOW_CYC,
   parameter int RECOVER_CYC = `RECOVERY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // User orders
   input wire logic cmd_valid,
   input wire flash_erase_pkg::cmd_e cmd,
   input wire logic [25:0] cmd_sector,
   output logic cmd_ready,
   output logic [15:0] status_data,
   output logic status_valid,
   output logic erase_busy,
   output logic suspended,
   output logic aborted,
   // Flash pins
   output flash_erase_pkg::flash_pins_s pins,
   input wire logic [15:0] dq_in,
   input wire logic ready_busy_n,
   input wire logic overlay_space
);
   import flash_erase_pkg::*;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_SETUP = 6'h02,
      S_LOW = 6'h04,
      S_HIGH = 6'h08,
      S_READ = 6'h10,
      S_RST = 6'h20
   } state_e;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_CHIP = 2'h1,
      OP_SECTOR = 2'h2
   } op_e;

   state_e state_r, state_nxt;
   op_e op_r, op_nxt;
   flash_pins_s pins_r, pins_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [2:0] len_r, len_nxt;
   logic [25:0] sect_r, sect_nxt;
   logic [15:0] code_r, code_nxt;
   logic [3:0] tick_r, tick_nxt;
   logic [31:0] wait_r, wait_nxt;
   logic [31:0] win_r, win_nxt;
   logic is_read_r, is_read_nxt;
   logic susp_r, susp_nxt;
   logic abort_r, abort_nxt;
   logic [15:0] stat_r, stat_nxt;
   logic sval_r, sval_nxt;
   logic busy_seen_r, busy_seen_nxt;

   // Address and data of write step i of a sequence
   function automatic logic [41:0] step(input logic [2:0] i,
      input logic [2:0] n, input logic [25:0] sa, input logic [15:0] c);
      logic [41:0] r;
      r = {sa, c};
      if (n == 3'h6)
      begin
         case (i)
            3'h0: r = {`UNLOCK_ADDR1, `UNLOCK_DATA1};
            3'h1: r = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
            3'h2: r = {`UNLOCK_ADDR1, `SETUP_DATA};
            3'h3: r = {`UNLOCK_ADDR1, `UNLOCK_DATA1};
            3'h4: r = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
            default: r = {sa, c};
         endcase
      end
      return r;
   endfunction : step

   // Sequencing of bus cycles and erase bookkeeping
   always_comb
   begin
      logic [41:0] ad;
      ad = '0;
      state_nxt = state_r;
      op_nxt = op_r;
      pins_nxt = pins_r;
      idx_nxt = idx_r;
      len_nxt = len_r;
      sect_nxt = sect_r;
      code_nxt = code_r;
      tick_nxt = tick_r;
      wait_nxt = wait_r;
      // Window runs only while idle, so it opens after the last sector write
      win_nxt = (win_r != 32'h0 && state_r == S_IDLE) ? win_r - 32'h1 : win_r;
      is_read_nxt = is_read_r;
      susp_nxt = susp_r;
      abort_nxt = abort_r;
      stat_nxt = stat_r;
      sval_nxt = 1'b0;
      busy_seen_nxt = busy_seen_r;
      // Erase completion seen through the busy pin
      if (op_r != OP_NONE && !susp_r && state_r == S_IDLE)
      begin
         if (!ready_busy_n)
            busy_seen_nxt = 1'b1;
         else if (busy_seen_r && win_r == 32'h0)
         begin
            op_nxt = OP_NONE;
            busy_seen_nxt = 1'b0;
         end
      end
      case (state_r)
         S_IDLE:
         begin
            if (cmd_valid)
            begin
               len_nxt = 3'h1;
               idx_nxt = 3'h0;
               is_read_nxt = 1'b0;
               sect_nxt = 26'h0;
               state_nxt = S_SETUP;
               case (cmd)
                  CMD_CHIP:
                  begin
                     len_nxt = 3'h6;
                     code_nxt = `CHIP_CODE;
                     sect_nxt = `UNLOCK_ADDR1; // Chip code goes to 555h
                     op_nxt = OP_CHIP;
                     abort_nxt = 1'b0;
                     busy_seen_nxt = 1'b0;
                  end
                  CMD_SECTOR:
                  begin
                     len_nxt = 3'h6;
                     code_nxt = `SECTOR_CODE;
                     sect_nxt = cmd_sector;
                     op_nxt = OP_SECTOR;
                     abort_nxt = 1'b0;
                     busy_seen_nxt = 1'b0;
                     win_nxt = ACCEPT_CYC;
                  end
                  CMD_ADD_SECTOR:
                  begin
                     code_nxt = `SECTOR_CODE;
                     sect_nxt = cmd_sector;
                     if (win_r == 32'h0)
                        state_nxt = S_IDLE;
                     else
                        win_nxt = ACCEPT_CYC;
                  end
                  CMD_SUSPEND:
                  begin
                     code_nxt = `SUSPEND_CODE;
                     if (op_r != OP_SECTOR || susp_r || overlay_space)
                        state_nxt = S_IDLE;
                  end
                  CMD_RESUME:
                  begin
                     code_nxt = `RESUME_CODE;
                     if (!susp_r || overlay_space)
                        state_nxt = S_IDLE;
                     else
                        susp_nxt = 1'b0;
                  end
                  CMD_STATUS:
                  begin
                     len_nxt = 3'h2;
                     code_nxt = `STATUS_READ_CODE;
                  end
                  CMD_CLEAR:
                  begin
                     code_nxt = `STATUS_CLEAR_CODE;
                  end
                  default:
                  begin
                     pins_nxt.reset_n = 1'b0;
                     wait_nxt = `RESET_PULSE_CYC;
                     op_nxt = OP_NONE;
                     susp_nxt = 1'b0;
                     win_nxt = 32'h0;
                     abort_nxt = (op_r != OP_NONE);
                     state_nxt = S_RST;
                  end
               endcase
            end
         end
         S_SETUP:
         begin
            if (len_r == 3'h2 && idx_r == 3'h1)
            begin
               pins_nxt.dq_oe = 1'b0;
               pins_nxt.ce_n = 1'b0;
               pins_nxt.oe_n = 1'b0;
               is_read_nxt = 1'b1;
            end
            else
            begin
               if (len_r == 3'h2)
                  ad = {`UNLOCK_ADDR1, code_r};
               else
                  ad = step(idx_r, len_r, sect_r, code_r);
               pins_nxt.addr = ad[41:16];
               pins_nxt.dq_out = ad[15:0];
               pins_nxt.dq_oe = 1'b1;
               pins_nxt.ce_n = 1'b0;
               pins_nxt.we_n = 1'b0;
            end
            tick_nxt = `STROBE_CYCLES;
            state_nxt = S_LOW;
         end
         S_LOW:
         begin
            tick_nxt = tick_r - 4'h1;
            if (tick_r == 4'h0)
            begin
               if (is_read_r)
               begin
                  stat_nxt = dq_in;
                  sval_nxt = 1'b1;
               end
               pins_nxt.we_n = 1'b1; // Rising strobe latches the write
               pins_nxt.oe_n = 1'b1;
               pins_nxt.ce_n = 1'b1;
               pins_nxt.dq_oe = 1'b0;
               tick_nxt = `STROBE_CYCLES;
               state_nxt = S_HIGH;
            end
         end
         S_HIGH:
         begin
            tick_nxt = tick_r - 4'h1;
            if (tick_r == 4'h0)
            begin
               idx_nxt = idx_r + 3'h1;
               state_nxt = (idx_r + 3'h1 == len_r) ? S_READ : S_SETUP;
            end
         end
         S_READ:
         begin
            // Suspend done once the device releases busy
            if (code_r == `SUSPEND_CODE)
            begin
               if (ready_busy_n)
               begin
                  susp_nxt = 1'b1;
                  state_nxt = S_IDLE;
               end
            end
            else
               state_nxt = S_IDLE;
         end
         S_RST:
         begin
            wait_nxt = wait_r - 32'h1;
            if (wait_r == 32'h0)
            begin
               if (!pins_r.reset_n)
               begin
                  pins_nxt.reset_n = 1'b1;
                  wait_nxt = RECOVER_CYC;
               end
               else
                  state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_r <= S_IDLE;
         op_r <= OP_NONE;
         pins_r <= '{addr: 26'h0, dq_out: 16'h0, dq_oe: 1'b0, we_n: 1'b1,
                     oe_n: 1'b1, ce_n: 1'b1, reset_n: 1'b1};
         idx_r <= 3'h0;
         len_r <= 3'h0;
         sect_r <= 26'h0;
         code_r <= 16'h0;
         tick_r <= 4'h0;
         wait_r <= 32'h0;
         win_r <= 32'h0;
         is_read_r <= 1'b0;
         susp_r <= 1'b0;
         abort_r <= 1'b0;
         stat_r <= 16'h0;
         sval_r <= 1'b0;
         busy_seen_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         pins_r <= pins_nxt;
         idx_r <= idx_nxt;
         len_r <= len_nxt;
         sect_r <= sect_nxt;
         code_r <= code_nxt;
         tick_r <= tick_nxt;
         wait_r <= wait_nxt;
         win_r <= win_nxt;
         is_read_r <= is_read_nxt;
         susp_r <= susp_nxt;
         abort_r <= abort_nxt;
         stat_r <= stat_nxt;
         sval_r <= sval_nxt;
         busy_seen_r <= busy_seen_nxt;
      end
   end

   // Outputs from flip-flops
   assign pins = pins_r;
   assign cmd_ready = (state_r == S_IDLE);
   assign status_data = stat_r;
   assign status_valid = sval_r;
   assign erase_busy = (op_r != OP_NONE);
   assign suspended = susp_r;
   assign aborted = abort_r;

   // Suspend is never written toward a chip erase
   property p_no_chip_suspend;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_SUSPEND
       && op_r == OP_CHIP) |=> state_r == S_IDLE;
   endproperty
   a_no_chip_suspend: assert property (p_no_chip_suspend)
      else $error("suspend issued during chip erase");

   // Hardware reset pulses the pin low next cycle
   property p_reset_pin;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_HW_RESET)
      |=> !pins_r.reset_n && op_r == OP_NONE;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("hardware reset not driven");

   // Overlay blocks resume
   property p_overlay;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_RESUME && overlay_space)
      |=> state_r == S_IDLE && $stable(susp_r);
   endproperty
   a_overlay: assert property (p_overlay)
      else $error("resume issued in overlay space");

   // First write of a six-write sequence is the unlock word
   property p_unlock;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_SETUP && len_r == 3'h6 && idx_r == 3'h0)
      |=> pins_r.addr == `UNLOCK_ADDR1 && pins_r.dq_out == `UNLOCK_DATA1
          && !pins_r.we_n;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("bad unlock write");

   // A starting erase arms busy reporting
   property p_chip_start;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_CHIP)
      |=> erase_busy ##1 !pins_r.we_n;
   endproperty
   a_chip_start: assert property (p_chip_start)
      else $error("chip erase not started");

   // Sector erase opens the acceptance window
   property p_window;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_SECTOR)
      |=> win_r == ACCEPT_CYC;
   endproperty
   a_window: assert property (p_window)
      else $error("window not opened");

   // Late add after window closed is dropped
   property p_late_add;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_ADD_SECTOR
       && win_r == 32'h0) |=> state_r == S_IDLE;
   endproperty
   a_late_add: assert property (p_late_add)
      else $error("late sector add issued");

   // Repeated resume is not written
   property p_resume;
      @(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && cmd_valid && cmd == CMD_RESUME && !susp_r)
      |=> state_r == S_IDLE;
   endproperty
   a_resume: assert property (p_resume)
      else $error("resume while not suspended");
endmodule : flash_erase_ctrl
`default_nettype wire

// ---- verif/flash_erase_model.sv ----
`default_nettype none
module flash_erase_model #(
   parameter int ERASE_CYC = 150,
   parameter int SUSP_CYC = 5,
   parameter int ACC_CYC = 20
) (
   // Timing reference
   input wire logic clk,
   // Bus from the controller
   input wire flash_erase_pkg::flash_pins_s pins,
   output logic [15:0] dq_in,
   output logic ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ns;
   `include "flash_erase_cfg.svh"
   logic we_q = 1'b1;
   logic ce_q = 1'b1;
   logic busy_m = 1'b0;
   logic susp_m = 1'b0;
   logic chip_m = 1'b0;
   logic [2:0] step = 3'h0;
   int tmr = 0;
   int stm = 0;
   logic [15:0] last = 16'h0000;
   wire logic [15:0] d = pins.dq_out;
   // Status word carries only the ready bit; skips never set error bits
   wire logic [15:0] sw = {8'h00, ~busy_m, 7'h00};
   assign ready_busy_n = ~busy_m;
   // Released bus shows the inverse of the last read
   assign dq_in = (!pins.oe_n && !pins.ce_n) ? sw : ~last;
   // Command decode on rising write strobe, erase and suspend timers
   always @(posedge clk)
   begin
      we_q <= pins.we_n;
      ce_q <= pins.ce_n;
      if (!pins.oe_n)
         last <= dq_in;
      if (!pins.reset_n)
      begin
         busy_m <= 1'b0;
         susp_m <= 1'b0;
         step <= 3'h0;
         stm <= 0;
      end
      else
      begin
         if (busy_m && stm == 0 && tmr > 0)
            tmr <= tmr - 1;
         if (busy_m && stm == 0 && tmr == 1)
            busy_m <= 1'b0;
         if (stm > 1)
            stm <= stm - 1;
         if (stm == 1)
         begin
            busy_m <= 1'b0;
            susp_m <= 1'b1;
            stm <= 0;
         end
         // Strobe and select rise together, so select is taken from before
         if (pins.we_n && !we_q && !ce_q)
         begin
            step <= 3'h0;
            if (busy_m && !chip_m && d == `SUSPEND_CODE)
               stm <= SUSP_CYC;
            else if (susp_m && d == `RESUME_CODE)
            begin
               susp_m <= 1'b0;
               busy_m <= 1'b1;
            end
            else if (busy_m && !chip_m && d == `SECTOR_CODE &&
                     tmr > ERASE_CYC - ACC_CYC)
               tmr <= ERASE_CYC;
            else if (!busy_m && !susp_m)
               case (step)
                  3'h0, 3'h3: if (pins.addr == `UNLOCK_ADDR1 &&
                                  d == `UNLOCK_DATA1) step <= step + 3'h1;
                  3'h1, 3'h4: if (pins.addr == `UNLOCK_ADDR2 &&
                                  d == `UNLOCK_DATA2) step <= step + 3'h1;
                  3'h2: if (pins.addr == `UNLOCK_ADDR1 &&
                            d == `SETUP_DATA) step <= 3'h3;
                  default: if (d == `CHIP_CODE || d == `SECTOR_CODE)
                  begin
                     busy_m <= 1'b1;
                     chip_m <= (d == `CHIP_CODE);
                     tmr <= ERASE_CYC;
                  end
               endcase
         end
      end
   end
endmodule : flash_erase_model
`default_nettype wire

// ---- verif/tb_flash_erase_sequencer.sv ----
`include "flash_erase_cfg.svh"
`default_nettype none
module tb_flash_erase_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_erase_pkg::*;
   localparam logic [25:0] SA = 26'h0010000;
   logic clk, rst_b, cmd_valid, overlay_space, cmd_ready, status_valid;
   logic erase_busy, suspended, aborted, ready_busy_n, we_q;
   logic rst_seen = 1'b0;
   cmd_e cmd;
   logic [25:0] cmd_sector;
   logic [15:0] status_data, dq_in;
   flash_pins_s pins;
   int n_mismatch, comparisons;
   logic [41:0] wlog[$];
   // Host window kept shorter than the device's acceptance window
   flash_erase_ctrl #(.ACCEPT_CYC(10), .RECOVER_CYC(20)) dut (.clk(clk),
      .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_sector(cmd_sector), .cmd_ready(cmd_ready),
      .status_data(status_data), .status_valid(status_valid),
      .erase_busy(erase_busy), .suspended(suspended), .aborted(aborted),
      .pins(pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n),
      .overlay_space(overlay_space));
   flash_erase_model #(.ACC_CYC(20)) flash (.clk(clk), .pins(pins),
      .dq_in(dq_in), .ready_busy_n(ready_busy_n));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Log every completed write cycle on the flash pins
   always @(posedge clk)
   begin
      we_q <= pins.we_n;
      if (pins.we_n && !we_q)
         wlog.push_back({pins.addr, pins.dq_out});
      if (pins.reset_n === 1'b0)
         rst_seen <= 1'b1;
   end
   task automatic chk(input logic [41:0] got, input logic [41:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic send(input cmd_e c, input logic [25:0] s);
      cmd <= c;
      cmd_sector <= s;
      cmd_valid <= 1'b1;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
   endtask : send
   function automatic logic sel(input int w);
      case (w)
         0: return cmd_ready;
         1: return erase_busy;
         2: return !erase_busy;
         default: return suspended;
      endcase
   endfunction : sel
   task automatic wait_on(input int w, input int lim);
      int i;
      @(posedge clk);
      for (i = 0; i < lim && sel(w) !== 1'b1; i++) @(posedge clk);
      chk(42'(sel(w)), 42'h1);
   endtask : wait_on
   task automatic chk_seq(input logic [15:0] code, input logic [25:0] sa);
      logic [41:0] e[6];
      e = '{{`UNLOCK_ADDR1, `UNLOCK_DATA1}, {`UNLOCK_ADDR2, `UNLOCK_DATA2},
         {`UNLOCK_ADDR1, `SETUP_DATA}, {`UNLOCK_ADDR1, `UNLOCK_DATA1},
         {`UNLOCK_ADDR2, `UNLOCK_DATA2}, {sa, code}};
      chk(42'(wlog.size()), 42'h6);
      foreach (e[i]) chk(wlog[i], e[i]);
      wlog.delete();
   endtask : chk_seq
   task automatic refused(input cmd_e c);
      wlog.delete();
      send(c, 26'h0);
      repeat (15) @(posedge clk);
      chk(42'(wlog.size()), 42'h0);
      chk(42'(cmd_ready), 42'h1);
   endtask : refused
   task automatic stat(input logic [15:0] e);
      int i;
      send(CMD_STATUS, 26'h0);
      for (i = 0; i < 60 && status_valid !== 1'b1; i++) @(posedge clk);
      chk(42'(status_valid), 42'h1);
      chk(42'(status_data), 42'(e));
      wlog.delete();
   endtask : stat
   task automatic start(input cmd_e c, input logic [15:0] code);
      wlog.delete();
      send(c, SA);
      wait_on(0, 200);
      chk_seq(code, (c == CMD_CHIP) ? `UNLOCK_ADDR1 : SA);
      wait_on(1, 50);
   endtask : start
   task automatic t_chip();
      stat(16'h0080);
      start(CMD_CHIP, `CHIP_CODE);
      stat(16'h0000);
      refused(CMD_SUSPEND);
      wait_on(2, 400);
      chk(42'(cmd_ready), 42'h1);
      $display("t_chip done");
   endtask : t_chip
   task automatic t_sector();
      start(CMD_SECTOR, `SECTOR_CODE);
      send(CMD_ADD_SECTOR, 26'h0);
      wait_on(0, 40);
      chk(wlog.pop_front(), {26'h0, `SECTOR_CODE});
      send(CMD_SUSPEND, 26'h0);
      wait_on(3, 100);
      chk(42'(wlog.pop_back() & 42'hffff), 42'(`SUSPEND_CODE));
      chk(42'(ready_busy_n), 42'h1);
      send(CMD_RESUME, 26'h0);
      wait_on(0, 40);
      chk(42'(suspended), 42'h0);
      refused(CMD_RESUME);
      send(CMD_SUSPEND, 26'h0);
      wait_on(3, 100);
      send(CMD_RESUME, 26'h0);
      wait_on(2, 600);
      $display("t_sector done");
   endtask : t_sector
   task automatic t_abort();
      start(CMD_SECTOR, `SECTOR_CODE);
      send(CMD_HW_RESET, 26'h0);
      wait_on(0, 100);
      chk(42'({rst_seen, aborted, erase_busy, pins.reset_n}),
         42'hd);
      start(CMD_SECTOR, `SECTOR_CODE);
      wait_on(2, 400);
      $display("t_abort done");
   endtask : t_abort
   task automatic t_overlay();
      start(CMD_SECTOR, `SECTOR_CODE);
      overlay_space <= 1'b1;
      refused(CMD_SUSPEND);
      overlay_space <= 1'b0;
      send(CMD_SUSPEND, 26'h0);
      wait_on(3, 100);
      overlay_space <= 1'b1;
      refused(CMD_RESUME);
      chk(42'(suspended), 42'h1);
      overlay_space <= 1'b0;
      send(CMD_RESUME, 26'h0);
      wait_on(2, 400);
      chk(42'(suspended), 42'h0);
      $display("t_overlay done");
   endtask : t_overlay
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   // Watchdog
   initial
   begin
      #1000000;
      n_mismatch++;
      end_sim();
   end
   // Main sequence
   initial
   begin
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd = CMD_CHIP;
      cmd_sector = 26'h0;
      overlay_space = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk(42'({pins.we_n, pins.oe_n, pins.ce_n, pins.reset_n, pins.dq_oe,
         cmd_ready, erase_busy}), 42'h7a);
      $display("t_reset done");
      t_chip();
      t_sector();
      t_abort();
      t_overlay();
      end_sim();
   end
endmodule : tb_flash_erase_sequencer
`default_nettype wire
